// >>> logic/pgpsc_cfg.sv
// power-good qualification, pin polarity and soft-start ramp configuration
// assumes a decoded internal register port from the serial bus front end
// and that all pins are already synchronous to core_clk
//
// Function
// (RULE1) ramp field 00/01/10/11 gives 360 us, 10 ms, 20 ms, 40 ms
// (RULE2) primary power good stays low until debounce after all conditions good
// (RULE3) debounce field bits 7:4: 0000 320, 0101 200, 1010 600, 1111 none
// (RULE4) same debounce applies before primary power good drops
// (RULE5) bit 3 lets even ignored flags pull secondary power good
// (RULE6) bits 2 and 0 invert flag input and supply-on input when set
// (RULE7) bit 1 set drives the oring transistor gate active low
// (RULE8) soft stop ramps down over the configured soft-start time
// (RULE9) enable source 01 uses the polarity-corrected supply-on input
// (RULE10) polarity 0 means active high; unknown debounce codes mean 320 ms
`timescale 1ns/1ps
module pgpsc_cfg
    import pgpsc_pkg::*;
#(
    parameter int unsigned NUM_FLAGS = 8,               // fault flag count
    parameter int unsigned NUM_QUAL  = 7,               // qualifying conditions
    parameter int unsigned SS0_CYC   = PGPSC_SS0_CYC,   // 360 us ramp
    parameter int unsigned SS1_CYC   = PGPSC_SS1_CYC,   // 10 ms ramp
    parameter int unsigned SS2_CYC   = PGPSC_SS2_CYC,   // 20 ms ramp
    parameter int unsigned SS3_CYC   = PGPSC_SS3_CYC,   // 40 ms ramp
    parameter int unsigned DB_A_CYC  = PGPSC_DB_A_CYC,  // 320 ms debounce
    parameter int unsigned DB_B_CYC  = PGPSC_DB_B_CYC,  // 200 ms debounce
    parameter int unsigned DB_C_CYC  = PGPSC_DB_C_CYC   // 600 ms debounce
) (
    input  wire logic                 core_clk,               // core clock
    input  wire logic                 rst_n,                  // async reset, active low
    input  wire logic [7:0]           regAddr,                // register offset
    input  wire logic [7:0]           regWrData,              // write data
    input  wire logic                 regWrEn,                // write strobe, one cycle
    input  wire logic                 regRdEn,                // read strobe, one cycle
    output logic      [7:0]           regRdData,              // read data, next cycle
    input  wire logic                 supply_on_input,        // supply-on pin, raw
    input  wire logic                 external_flag_input,    // external flag pin, raw
    input  wire logic                 oringOnReq,             // request to close oring switch
    input  wire logic [NUM_QUAL-1:0]  qualifyOk,              // supply, ocp, uvp, ovp, load good
    input  wire logic [NUM_FLAGS-1:0] flagActive,             // fault flags raised
    input  wire logic [NUM_FLAGS-1:0] flagIgnore,             // flags set to be ignored
    output logic                      power_good_primary_out, // primary power good
    output logic                      power_good_secondary_out, // secondary power good
    output logic                      oring_transistor,       // gate drive pin level
    output logic                      externalFlagOn,         // flag input, corrected
    output logic                      supply_on_control,      // supply enabled
    output logic      [7:0]           rampLevel,              // output reference, 0..255
    output logic                      rampBusy                // ramp in progress
);
    logic [7:0]   polarity_q;
    logic [7:0]   softCtl_q;
    pgpsc_state_t state_q;
    pgpsc_state_t state_d;
    logic [23:0]  stepCnt_q;

    // register decode
    wire hitPol  = regAddr == PGPSC_POLARITY_OFFSET;
    wire hitSoft = regAddr == PGPSC_SOFTCTL_OFFSET;
    wire [7:0] rdMux = hitPol  ? polarity_q :
                       hitSoft ? softCtl_q  : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            polarity_q <= PGPSC_POLARITY_RESET;
            softCtl_q  <= PGPSC_SOFTCTL_RESET;
            regRdData  <= 8'h00;
        end else begin
            if (regWrEn && hitPol) polarity_q <= regWrData;
            if (regWrEn && hitSoft) softCtl_q <= regWrData;
            if (regRdEn) regRdData <= rdMux;
        end
    end

    // pin polarity: 0 active high, 1 inverted
    wire flagLevel = external_flag_input ^ polarity_q[PGPSC_FLAG_POL_BIT]; // RULE6 RULE10
    wire sonLevel  = supply_on_input ^ polarity_q[PGPSC_SON_POL_BIT];      // RULE6 RULE10
    wire gateLevel = oringOnReq ^ polarity_q[PGPSC_GATE_POL_BIT];         // RULE7

    // enable source select
    wire [1:0] srcSel = softCtl_q[PGPSC_SRC_MSB:PGPSC_SRC_LSB];
    wire       swOn   = softCtl_q[PGPSC_SW_ON_BIT];
    wire enableNow = (srcSel == PGPSC_SRC_ALWAYS) ? 1'b1 :
                     (srcSel == PGPSC_SRC_PIN)    ? sonLevel :  // RULE9
                     (srcSel == PGPSC_SRC_SW)     ? swOn :
                                                    (swOn && sonLevel);

    // secondary power good: ignored flags count only with bit 3 set
    wire [NUM_FLAGS-1:0] flagMask = polarity_q[PGPSC_PG2_ALL_BIT] ? {NUM_FLAGS{1'b1}} : ~flagIgnore;
    wire anyFlag = |(flagActive & flagMask); // RULE5

    // debounce period; reserved codes fall back to the 320 ms period
    wire [3:0] dbCode = polarity_q[PGPSC_DB_MSB:PGPSC_DB_LSB];
    wire [23:0] dbLimit = (dbCode == PGPSC_DB_CODE_200) ? DB_B_CYC[23:0] : // RULE3
                          (dbCode == PGPSC_DB_CODE_600) ? DB_C_CYC[23:0] :
                          (dbCode == PGPSC_DB_CODE_0)   ? 24'h000000 :
                                                          DB_A_CYC[23:0]; // RULE10

    // primary power good needs every condition and a finished ramp
    wire allGood = (&qualifyOk) && (state_q == PGPSC_ST_ON);
    logic pg1Clean;

    // one debouncer serves both edges, so rise and fall wait equally
    pgpsc_debounce u_pg1_db (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .rawIn    (allGood),  // RULE2 RULE4
        .limit    (dbLimit),
        .cleanOut (pg1Clean)
    );

    // ramp step length: full ramp time spread over 256 steps
    wire [1:0] ssSel = softCtl_q[PGPSC_SS_MSB:PGPSC_SS_LSB];
    wire [23:0] stepLen = (ssSel == 2'b00) ? 24'((SS0_CYC + PGPSC_RAMP_STEPS - 1) / PGPSC_RAMP_STEPS) : // RULE1
                          (ssSel == 2'b01) ? 24'((SS1_CYC + PGPSC_RAMP_STEPS - 1) / PGPSC_RAMP_STEPS) :
                          (ssSel == 2'b10) ? 24'((SS2_CYC + PGPSC_RAMP_STEPS - 1) / PGPSC_RAMP_STEPS) :
                                             24'((SS3_CYC + PGPSC_RAMP_STEPS - 1) / PGPSC_RAMP_STEPS);
    wire stepTick = stepCnt_q + 24'h000001 >= stepLen;
    wire softStop = softCtl_q[PGPSC_SSTOP_BIT];

    // ramp sequencer; without soft stop the output drops at once
    always_comb begin
        state_d = state_q;
        case (state_q)
            PGPSC_ST_OFF: begin
                if (enableNow) state_d = PGPSC_ST_UP;
            end
            PGPSC_ST_UP: begin
                if (!enableNow) state_d = softStop ? PGPSC_ST_DOWN : PGPSC_ST_OFF; // RULE8
                else if (stepTick && rampLevel == 8'hff) state_d = PGPSC_ST_ON;
            end
            PGPSC_ST_ON: begin
                if (!enableNow) state_d = softStop ? PGPSC_ST_DOWN : PGPSC_ST_OFF; // RULE8
            end
            PGPSC_ST_DOWN: begin
                if (enableNow) state_d = PGPSC_ST_UP;
                else if (stepTick && rampLevel == 8'h00) state_d = PGPSC_ST_OFF;
            end
            default: state_d = PGPSC_ST_OFF;
        endcase
    end

    // ramp level moves one step per tick; down uses the same step length
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= PGPSC_ST_OFF;
            stepCnt_q <= 24'h000000;
            rampLevel <= 8'h00;
        end else begin
            state_q   <= state_d;
            stepCnt_q <= (stepTick || state_q == PGPSC_ST_OFF || state_q == PGPSC_ST_ON) ? 24'h000000
                                                                                      : stepCnt_q + 24'h000001;
            if (state_d == PGPSC_ST_OFF) rampLevel <= 8'h00;
            else if (state_d == PGPSC_ST_ON) rampLevel <= 8'hff;
            else if (stepTick && state_q == PGPSC_ST_UP && rampLevel != 8'hff) rampLevel <= rampLevel + 8'h01; // RULE1
            else if (stepTick && state_q == PGPSC_ST_DOWN && rampLevel != 8'h00) rampLevel <= rampLevel - 8'h01; // RULE8
        end
    end

    // registered pin-facing outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_good_primary_out   <= 1'b0;
            power_good_secondary_out <= 1'b0;
            oring_transistor         <= 1'b0;
            externalFlagOn           <= 1'b0;
            supply_on_control        <= 1'b0;
            rampBusy                 <= 1'b0;
        end else begin
            power_good_primary_out   <= pg1Clean;          // RULE2
            power_good_secondary_out <= pg1Clean && !anyFlag; // RULE5
            oring_transistor         <= gateLevel;         // RULE7
            externalFlagOn           <= flagLevel;         // RULE6
            supply_on_control        <= enableNow;         // RULE9
            rampBusy                 <= state_d == PGPSC_ST_UP || state_d == PGPSC_ST_DOWN;
        end
    end
endmodule : pgpsc_cfg

// >>> logic/pgpsc_debounce.sv
// symmetric debounce: output follows input once it differed for limit cycles
// assumes limit is stable while counting; a change of limit restarts nothing
`timescale 1ns/1ps
module pgpsc_debounce (
    input  wire logic        core_clk,  // core clock
    input  wire logic        rst_n,     // async reset, active low
    input  wire logic        rawIn,     // level to qualify
    input  wire logic [23:0] limit,     // cycles to persist, 0 = no delay
    output logic             cleanOut   // debounced level
);
    logic [23:0] cnt_q;
    logic        differ;
    logic        expire;

    // input must persist against the output for the whole period
    assign differ = rawIn != cleanOut;
    assign expire = (limit == 24'h000000) || (cnt_q + 24'h000001 >= limit);

    // a glitch back to the output level restarts the period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= 24'h000000;
            cleanOut <= 1'b0;
        end else if (!differ) begin
            cnt_q <= 24'h000000;
        end else if (expire) begin
            cnt_q    <= 24'h000000;
            cleanOut <= rawIn;
        end else begin
            cnt_q <= cnt_q + 24'h000001;
        end
    end
endmodule : pgpsc_debounce

// >>> shared/pgpsc_pkg.sv
// constants for the power-good, polarity and soft-start configuration block
// assumes a single 20 MHz core clock; times are converted to cycles here
package pgpsc_pkg;
    // register offsets and reset values
    localparam logic [7:0] PGPSC_POLARITY_OFFSET = 8'h2d;
    localparam logic [7:0] PGPSC_SOFTCTL_OFFSET  = 8'h2c;
    localparam logic [7:0] PGPSC_POLARITY_RESET  = 8'h00;
    localparam logic [7:0] PGPSC_SOFTCTL_RESET   = 8'h00;
    // polarity register fields
    localparam int PGPSC_DB_MSB       = 7;
    localparam int PGPSC_DB_LSB       = 4;
    localparam int PGPSC_PG2_ALL_BIT  = 3;
    localparam int PGPSC_FLAG_POL_BIT = 2;
    localparam int PGPSC_GATE_POL_BIT = 1;
    localparam int PGPSC_SON_POL_BIT  = 0;
    // soft control register fields
    localparam int PGPSC_SRC_MSB      = 7;
    localparam int PGPSC_SRC_LSB      = 6;
    localparam int PGPSC_SW_ON_BIT    = 5;
    localparam int PGPSC_SSTOP_BIT    = 2;
    localparam int PGPSC_SS_MSB       = 1;
    localparam int PGPSC_SS_LSB       = 0;
    // debounce codes
    localparam logic [3:0] PGPSC_DB_CODE_320 = 4'h0;
    localparam logic [3:0] PGPSC_DB_CODE_200 = 4'h5;
    localparam logic [3:0] PGPSC_DB_CODE_600 = 4'ha;
    localparam logic [3:0] PGPSC_DB_CODE_0   = 4'hf;
    // timing, in the units printed
    localparam int unsigned PGPSC_CLK_KHZ   = 20000;
    localparam int unsigned PGPSC_SS0_US    = 360;
    localparam int unsigned PGPSC_SS1_MS    = 10;
    localparam int unsigned PGPSC_SS2_MS    = 20;
    localparam int unsigned PGPSC_SS3_MS    = 40;
    localparam int unsigned PGPSC_DB_A_MS   = 320;
    localparam int unsigned PGPSC_DB_B_MS   = 200;
    localparam int unsigned PGPSC_DB_C_MS   = 600;
    localparam int unsigned PGPSC_RAMP_STEPS = 256;
    // full ramp and debounce times as cycles (long counts, top overrides)
    localparam int unsigned PGPSC_SS0_CYC = PGPSC_SS0_US * PGPSC_CLK_KHZ / 1000;
    localparam int unsigned PGPSC_SS1_CYC = PGPSC_SS1_MS * PGPSC_CLK_KHZ;
    localparam int unsigned PGPSC_SS2_CYC = PGPSC_SS2_MS * PGPSC_CLK_KHZ;
    localparam int unsigned PGPSC_SS3_CYC = PGPSC_SS3_MS * PGPSC_CLK_KHZ;
    localparam int unsigned PGPSC_DB_A_CYC = PGPSC_DB_A_MS * PGPSC_CLK_KHZ;
    localparam int unsigned PGPSC_DB_B_CYC = PGPSC_DB_B_MS * PGPSC_CLK_KHZ;
    localparam int unsigned PGPSC_DB_C_CYC = PGPSC_DB_C_MS * PGPSC_CLK_KHZ;
    // enable source selections
    typedef enum logic [1:0] {
        PGPSC_SRC_ALWAYS = 2'b00,
        PGPSC_SRC_PIN    = 2'b01,
        PGPSC_SRC_SW     = 2'b10,
        PGPSC_SRC_BOTH   = 2'b11
    } pgpsc_src_t;
    // soft start ramp states
    typedef enum logic [1:0] {
        PGPSC_ST_OFF  = 2'b00,
        PGPSC_ST_UP   = 2'b01,
        PGPSC_ST_ON   = 2'b10,
        PGPSC_ST_DOWN = 2'b11
    } pgpsc_state_t;
endpackage : pgpsc_pkg

// >>> testbench/pgpsc_cfg_props.sv
// checker: register shadow, pin polarity and power-good timing
// sees the top ports only; bound into every instance of the top
`timescale 1ns/1ps
module pgpsc_cfg_props
    import pgpsc_pkg::*;
#(
    parameter int unsigned NUM_FLAGS = 8,              // flag count
    parameter int unsigned NUM_QUAL  = 7,              // condition count
    parameter int unsigned DB_A_CYC  = PGPSC_DB_A_CYC, // 320 ms debounce
    parameter int unsigned DB_B_CYC  = PGPSC_DB_B_CYC, // 200 ms debounce
    parameter int unsigned DB_C_CYC  = PGPSC_DB_C_CYC  // 600 ms debounce
) (
    input wire logic                 core_clk,                 // clock
    input wire logic                 rst_n,                    // reset
    input wire logic [7:0]           regAddr,                  // offset
    input wire logic [7:0]           regWrData,                // write data
    input wire logic                 regWrEn,                  // write
    input wire logic                 regRdEn,                  // read
    input wire logic [7:0]           regRdData,                // read data
    input wire logic                 external_flag_input,      // flag pin
    input wire logic                 oringOnReq,               // switch request
    input wire logic [NUM_QUAL-1:0]  qualifyOk,                // conditions
    input wire logic [NUM_FLAGS-1:0] flagActive,               // flags
    input wire logic [NUM_FLAGS-1:0] flagIgnore,               // ignore mask
    input wire logic                 power_good_primary_out,   // primary
    input wire logic                 power_good_secondary_out, // secondary
    input wire logic                 oring_transistor,         // gate pin
    input wire logic                 externalFlagOn,           // flag state
    input wire logic [7:0]           rampLevel,                // ramp level
    input wire logic                 rampBusy                  // ramp moving
);
    logic [7:0]  polQ;    // shadow of the polarity register
    logic [23:0] goodCnt; // cycles with all conditions good
    logic [23:0] badCnt;  // cycles not good or ramp not at top
    // reserved codes fall back to the 320 ms default
    wire [3:0]  dbCode = polQ[7:4];
    wire [23:0] lim = (dbCode == PGPSC_DB_CODE_0) ? 24'h0 : (dbCode == PGPSC_DB_CODE_200) ? 24'(DB_B_CYC) :
                      (dbCode == PGPSC_DB_CODE_600) ? 24'(DB_C_CYC) : 24'(DB_A_CYC);
    wire allOk = &qualifyOk;
    // the ramp sits at full scale for one step before it is settled, so busy must be low too
    wire onOk = allOk && rampLevel == 8'hff && !rampBusy;
    wire [NUM_FLAGS-1:0] counted = flagActive & (polQ[3] ? {NUM_FLAGS{1'b1}} : ~flagIgnore);
    // shadow and run-length counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            polQ    <= PGPSC_POLARITY_RESET;
            goodCnt <= 24'h0;
            badCnt  <= 24'h0;
        end else begin
            if (regWrEn && regAddr == PGPSC_POLARITY_OFFSET) begin
                polQ <= regWrData;
            end
            goodCnt <= allOk ? goodCnt + 24'h1 : 24'h0;
            badCnt  <= onOk ? 24'h0 : badCnt + 24'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence pgRiseS;
        !power_good_primary_out ##1 power_good_primary_out;
    endsequence
    sequence pgFallS;
        power_good_primary_out ##1 !power_good_primary_out;
    endsequence
    AST_RD_POL: assert property (regRdEn && !regWrEn && regAddr == PGPSC_POLARITY_OFFSET |=> regRdData == $past(polQ))
        else $error("polarity register read back wrong");
    AST_RD_UNMAPPED: assert property (regRdEn && regAddr != 8'h2c && regAddr != 8'h2d |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data moved without a read");
    AST_FLAG_POL: assert property ($past(rst_n) |-> externalFlagOn == $past(external_flag_input ^ polQ[2]))
        else $error("flag input polarity wrong");
    AST_GATE_POL: assert property ($past(rst_n) |-> oring_transistor == $past(oringOnReq ^ polQ[1]))
        else $error("switch gate polarity wrong");
    AST_PG_RISE: assert property (pgRiseS |-> goodCnt > lim)
        else $error("primary power good rose before debounce");
    AST_PG_FALL: assert property (pgFallS |-> badCnt >= lim)
        else $error("primary power good fell before debounce");
    AST_PG_SECOND: assert property (power_good_secondary_out |-> power_good_primary_out && !$past(|counted))
        else $error("secondary power good high with a counted flag");
endmodule : pgpsc_cfg_props

bind pgpsc_cfg pgpsc_cfg_props #(.NUM_FLAGS(NUM_FLAGS), .NUM_QUAL(NUM_QUAL), .DB_A_CYC(DB_A_CYC),
    .DB_B_CYC(DB_B_CYC), .DB_C_CYC(DB_C_CYC)) u_props (.*);

// >>> testbench/pgpsc_pin_model.sv
// board side of the supply-on and flag pins
// takes the wanted logical state and the polarity the board is wired for
`timescale 1ns/1ps
module pgpsc_pin_model (
    input  wire logic       onWant,             // supply wanted on
    input  wire logic       flagWant,           // flag raised
    input  wire logic [1:0] pol,                // {flag, supply} active low
    output logic            supply_on_input,    // raw pin
    output logic            external_flag_input // raw pin
);
    // an active-low board pulls the pin low for on
    assign supply_on_input     = onWant ^ pol[0];
    assign external_flag_input = flagWant ^ pol[1];
endmodule : pgpsc_pin_model

// >>> testbench/tb_top.sv
// testbench: register access, ramp timing, debounce, pin polarity
// inputs move on the falling edge; pins come from the pin model
`timescale 1ns/1ps
module tb_top;
    import pgpsc_pkg::*;
    localparam int DBA = 40;
    localparam int DBB = 25;
    localparam int DBC = 75;
    logic       core_clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, oringOnReq = 1'b0;
    logic       onWant = 1'b0, flagWant = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, flagActive = 8'h00, flagIgnore = 8'h00, regRdData, rampLevel, d;
    logic [6:0] qualifyOk = 7'h00;
    logic [2:0] polSet = 3'h0;
    logic       supply_on_input, external_flag_input, power_good_primary_out, power_good_secondary_out;
    logic       oring_transistor, externalFlagOn, supply_on_control, rampBusy;
    logic [3:0] dbCode [5] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h3};
    int         dbLim [5] = '{DBA, DBB, DBC, 0, DBA};
    int         mismatches = 0, n_checks = 0, n;
    always #25 core_clk = ~core_clk;
    // short ramp and debounce counts keep the run brief
    pgpsc_cfg #(.SS0_CYC(512), .SS1_CYC(1024), .SS2_CYC(1536), .SS3_CYC(2048), .DB_A_CYC(DBA), .DB_B_CYC(DBB),
        .DB_C_CYC(DBC)) dut (.*);
    pgpsc_pin_model pins (.onWant(onWant), .flagWant(flagWant), .pol({polSet[2], polSet[0]}),
        .supply_on_input(supply_on_input), .external_flag_input(external_flag_input));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        // one idle cycle so a following call never re-raises the strobe in this step
        @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        v = regRdData;
        @(negedge core_clk);
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkCnt(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : chkCnt
    task automatic waitRamp(input logic [7:0] lvl, output int cnt);
        cnt = 0;
        while (!(rampLevel === lvl && rampBusy === 1'b0) && cnt < 5000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : waitRamp
    task automatic waitPg(input logic lvl, output int cnt);
        cnt = 0;
        while (power_good_primary_out !== lvl && cnt < 3000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : waitPg
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // cut a hang at about three and a half times the expected run
    initial begin
        #(50 * 40000);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        rd(PGPSC_POLARITY_OFFSET, d);
        chk(d, 8'h00);
        wr(8'h2d, 8'hf6);
        wr(8'h30, 8'h5a);
        rd(8'h2d, d);
        chk(d, 8'hf6);
        rd(8'h30, d);
        chk(d, 8'h00);
        // software source: ramp up, then soft stop down, each ramp code
        wr(8'h2c, 8'h80);
        for (int c = 0; c < 4; c++) begin
            wr(8'h2c, 8'ha0 | 8'(c));
            waitRamp(8'hff, n);
            chkCnt(n, 508 * (c + 1), 512 * (c + 1) + 3);
            wr(8'h2c, 8'h84 | 8'(c));
            waitRamp(8'h00, n);
            chkCnt(n, 508 * (c + 1), 512 * (c + 1) + 3);
        end
        wr(8'h2c, 8'ha0);
        waitRamp(8'hff, n);
        foreach (dbCode[k]) begin
            wr(8'h2d, {dbCode[k], 4'h0});
            qualifyOk = 7'h7f;
            waitPg(1'b1, n);
            chkCnt(n, dbLim[k] + 1, dbLim[k] + 4);
            qualifyOk = 7'h7e;
            waitPg(1'b0, n);
            chkCnt(n, dbLim[k] + 1, dbLim[k] + 4);
        end
        // one raised flag: ignored, counted, then forced by bit 3
        qualifyOk = 7'h7f;
        flagActive = 8'h01;
        waitPg(1'b1, n);
        for (int k = 0; k < 3; k++) begin
            flagIgnore = (k == 1) ? 8'h00 : 8'h01;
            wr(8'h2d, (k == 2) ? 8'hf8 : 8'hf0);
            repeat (3) @(negedge core_clk);
            chk({7'h0, power_good_secondary_out}, {7'h0, k == 0});
        end
        flagActive = 8'h00;
        wr(8'h2c, 8'h40);
        for (int i = 0; i < 16; i++) begin
            polSet = i[2:0];
            onWant = i[3];
            flagWant = !i[3];
            oringOnReq = i[3];
            wr(8'h2d, {5'h1e, i[2:0]});
            repeat (2) @(negedge core_clk);
            chk({7'h0, externalFlagOn}, {7'h0, !i[3]});
            chk({7'h0, supply_on_control}, {7'h0, i[3]});
            chk({7'h0, oring_transistor}, {7'h0, i[3] ^ i[1]});
        end
        // both sources needed, then always on regardless of the pin
        wr(PGPSC_SOFTCTL_OFFSET, 8'he0);
        chk({7'h0, supply_on_control}, 8'h01);
        onWant = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({7'h0, supply_on_control}, 8'h00);
        wr(PGPSC_SOFTCTL_OFFSET, 8'h00);
        chk({7'h0, supply_on_control}, 8'h01);
        complete_run();
    end
endmodule : tb_top
